// ==== cmd_parser_map.svh ====
// Purpose: constants of the ascii command parser
// Assumes: 8-bit ascii characters from a byte receiver
// Notes:
`ifndef CMD_PARSER_MAP_SVH
`define CMD_PARSER_MAP_SVH
`define CHR_CR 8'h0D
`define CHR_BANG 8'h21
`define CHR_GT 8'h3E
`define CHR_QM 8'h3F
`define CHR_PCT 8'h25
`define CHR_DOLLAR 8'h24
`define CHR_HASH 8'h23
`define CHR_AT 8'h40
`define CHR_TILDE 8'h7E
`define CHR_STAR 8'h2A
`define CHR_0 8'h30
`define CHR_1 8'h31
`define CHR_9 8'h39
`define CHR_A 8'h41
`define CHR_D 8'h44
`define CHR_E 8'h45
`define CHR_F 8'h46
`define CHR_G 8'h47
`define CHR_H 8'h48
`define CHR_I 8'h49
`define CHR_L 8'h4C
`define CHR_M 8'h4D
`define CHR_O 8'h4F
`define CHR_P 8'h50
`define CHR_R 8'h52
`define CHR_S 8'h53
`define RX_DEPTH 16
`define RSP_BYTES 15
`define MAX_NIBBLES 12
`define LEAD_ARGS 6
`define CFG_ARGS 8
`define ADDR_RESET 8'h01
`define ADDR_DEFAULT 8'h00
`define TYPE_COUNTER 8'h50
`define TYPE_FREQ 8'h51
`define BAUD_RESET 8'h06
`define BAUD_MIN 8'h03
`define BAUD_MAX 8'h08
`define BPS_BASE 16'h04B0
`define FLAG_RESET 8'h00
`define FLAG_CKS_BIT 6
`define FLAG_GATE_BIT 7
`define NAME_CODE 16'h1234
`define REV_CODE 16'h0100
`endif

// ==== cmd_parser_pkg.sv ====
// Purpose: shared types and hex helpers of the command parser
// Assumes: upper-case hex digits on the line
// Notes: both design files use the helpers
`include "cmd_parser_map.svh"
package cmd_parser_pkg;
	typedef enum logic [5:0] {
		OP_NONE, OP_SET_MODE, OP_RD_MODE, OP_RD_CNT_HEX, OP_RD_CNT_DEC,
		OP_SET_GATE, OP_RD_GATE, OP_SET_MAX, OP_RD_MAX, OP_SET_INIT,
		OP_RD_INIT, OP_SET_RUN, OP_RD_RUN, OP_CLR_CNT, OP_RD_OVF,
		OP_SET_FILT, OP_RD_FILT, OP_SET_MINH, OP_RD_MINH, OP_SET_MINL,
		OP_RD_MINL, OP_SET_TRGH, OP_RD_TRGH, OP_SET_TRGL, OP_RD_TRGL,
		OP_ALM_ON, OP_ALM_OFF, OP_SET_LIM0, OP_SET_LIM1, OP_RD_LIM0,
		OP_RD_LIM1, OP_SET_DOUT, OP_RD_DOUT, OP_RD_LEAD, OP_SET_LEAD,
		OP_SET_WDOG, OP_RD_WDOG
	} opcode_t;
	typedef enum logic [1:0] {
		S_RECV = 2'h0, S_EXEC = 2'h1, S_WAIT = 2'h3, S_SEND = 2'h2
	} pstate_t;
	typedef enum logic [2:0] {
		ACT_DROP, ACT_WILD, ACT_CFG_SET, ACT_CFG_RD, ACT_NAME, ACT_REV, ACT_EXT
	} act_t;
	typedef struct packed {
		opcode_t     op;
		logic        channel_select;
		logic [47:0] arg;
		logic [3:0]  arg_len;
	} cmd_t;
	typedef struct packed {
		logic        ok;
		logic [47:0] data;
		logic [3:0]  len;
	} rsp_t;

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < 4'hA) ? (`CHR_0 + {4'h0, n}) : (`CHR_A + {4'h0, n} - 8'h0A);
	endfunction : hex_char

	// bit 4 marks a valid digit
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= `CHR_0 && c <= `CHR_9) return {1'b1, c[3:0]};
		if (c >= `CHR_A && c <= `CHR_F) return {1'b1, 4'(c[3:0] + 4'h9)};
		return 5'h00;
	endfunction : hex_val
endpackage : cmd_parser_pkg

// ==== resp_sender.sv ====
// Purpose: serialises one response, adds checksum and terminator
// Assumes: start only while not busy
// Notes: message byte 0 leaves first
`timescale 1ns/1ps
`include "cmd_parser_map.svh"
module resp_sender (
	input  logic                      ref_clk,
	input  logic                      rst,
	input  logic                      ce,
	input  logic                      start,
	input  logic [`RSP_BYTES*8-1:0]   msg,
	input  logic [3:0]                msg_len,
	input  logic                      cks_en,
	input  logic                      tx_ready,
	output logic                      tx_valid,
	output logic [7:0]                tx_data,
	output logic                      busy
);
	logic [`RSP_BYTES*8-1:0] msg_q;
	logic [4:0]              len_q;
	logic [4:0]              idx_q;
	logic [4:0]              last;
	logic [7:0]              sum_q;
	logic                    cks_q;

	// index of the terminator byte
	assign last = len_q + (cks_q ? 5'h02 : 5'h00);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busy     <= 1'b0;
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			msg_q    <= '0;
			len_q    <= 5'h00;
			idx_q    <= 5'h00;
			sum_q    <= 8'h00;
			cks_q    <= 1'b0;
		end else if (ce) begin
			if (!busy) begin
				if (start) begin
					msg_q <= msg;
					len_q <= {1'b0, msg_len};
					cks_q <= cks_en;
					idx_q <= 5'h00;
					sum_q <= 8'h00;
					busy  <= 1'b1;
				end
			end else if (!tx_valid || tx_ready) begin
				if (idx_q > last) begin
					tx_valid <= 1'b0;
					busy     <= 1'b0;
				end else begin
					tx_valid <= 1'b1;
					idx_q    <= idx_q + 5'h01;
					if (idx_q < len_q) begin
						tx_data <= msg_q[idx_q[3:0]*8 +: 8];
						sum_q   <= sum_q + msg_q[idx_q[3:0]*8 +: 8];
					end else if (idx_q == last) begin
						tx_data <= `CHR_CR;
					end else if (idx_q == len_q) begin
						tx_data <= cmd_parser_pkg::hex_char(sum_q[7:4]);
					end else begin
						tx_data <= cmd_parser_pkg::hex_char(sum_q[3:0]);
					end
				end
			end
		end
	end
endmodule : resp_sender

// ==== ascii_command_parser.sv ====
// Purpose: ascii command frame parser and dispatcher
// Assumes: rx bytes arrive one per rx_valid pulse, half duplex
// Notes: datapath answers forwarded commands on rsp_valid
`timescale 1ns/1ps
`include "cmd_parser_map.svh"
module ascii_command_parser (
	input  logic                    ref_clk,
	input  logic                    rst,
	input  logic                    ce,
	input  logic                    rx_valid,
	input  logic [7:0]              rx_data,
	input  logic                    tx_ready,
	output logic                    tx_valid,
	output logic [7:0]              tx_data,
	input  logic                    default_n,
	output logic                    cmd_valid,
	output cmd_parser_pkg::cmd_t    cmd,
	input  logic                    rsp_valid,
	input  cmd_parser_pkg::rsp_t    rsp,
	output logic                    host_alive,
	output logic [7:0]              station_id,
	output logic [7:0]              function_code,
	output logic [7:0]              baud_code,
	output logic [7:0]              integrity_field,
	output logic [15:0]             line_bps,
	output logic                    default_state
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [95:0] hex_str(input logic [47:0] w, input logic [3:0] n);
		logic [95:0] r;
		r = '0;
		for (int k = 0; k < `MAX_NIBBLES; k++) begin
			if (k < int'(n)) r[k*8 +: 8] = cmd_parser_pkg::hex_char(w[(int'(n)-1-k)*4 +: 4]);
		end
		return r;
	endfunction : hex_str

	function automatic logic [15:0] addr_chars(input logic [7:0] a);
		return {cmd_parser_pkg::hex_char(a[3:0]), cmd_parser_pkg::hex_char(a[7:4])};
	endfunction : addr_chars

	// ****************************************
	// state
	// ****************************************
	logic [7:0]               buf_q [`RX_DEPTH];
	logic [4:0]               len_q;
	logic [7:0]               sum_q;
	logic                     ovf_q;
	cmd_parser_pkg::pstate_t  state_q;
	logic [7:0]               addr_q;
	logic [7:0]               type_q;
	logic [7:0]               baud_q;
	logic [7:0]               flag_q;
	logic                     strap_q;
	logic [`RSP_BYTES*8-1:0]  resp_q;
	logic [3:0]               resp_len_q;
	logic                     resp_cks_q;
	logic                     send_start_q;
	logic [7:0]               hold_addr_q;
	logic                     hold_hash_q;
	logic                     busy;

	// ****************************************
	// frame decode
	// ****************************************
	logic [7:0]               my_addr;
	logic                     cks_on;
	logic [4:0]               pend;
	logic [7:0]               calc_sum;
	logic [4:0]               ck_hi;
	logic [4:0]               ck_lo;
	logic                     frame_ok;
	logic [4:0]               a_hi;
	logic [4:0]               a_lo;
	logic [7:0]               rx_addr;
	logic                     is_wild;
	logic [4:0]               c1;
	logic [4:0]               s_idx;
	logic                     has_ch;
	logic                     raw;
	cmd_parser_pkg::opcode_t  op_rd;
	cmd_parser_pkg::opcode_t  op_wr;
	cmd_parser_pkg::opcode_t  op;
	cmd_parser_pkg::act_t     loc;
	cmd_parser_pkg::act_t     act;
	logic [47:0]              arg;
	logic [4:0]               cnt;
	logic                     all_hex;
	logic                     ch_ok;
	logic [4:0]               ch_pos;
	logic                     syntax_ok;
	logic                     cfg_ok;

	assign my_addr = strap_q ? `ADDR_DEFAULT : addr_q;
	assign cks_on  = flag_q[`FLAG_CKS_BIT] && !strap_q;

	always_comb begin
		pend     = len_q - (cks_on ? 5'h02 : 5'h00);
		// sum of everything except the two trailing checksum characters
		calc_sum = sum_q - buf_q[4'(len_q - 5'h02)] - buf_q[4'(len_q - 5'h01)];
		ck_hi    = cmd_parser_pkg::hex_val(buf_q[4'(len_q - 5'h02)]);
		ck_lo    = cmd_parser_pkg::hex_val(buf_q[4'(len_q - 5'h01)]);
		frame_ok = !ovf_q && len_q >= (cks_on ? 5'h05 : 5'h03);
		if (cks_on && !(ck_hi[4] && ck_lo[4] && {ck_hi[3:0], ck_lo[3:0]} == calc_sum))
			frame_ok = 1'b0;
		a_hi    = cmd_parser_pkg::hex_val(buf_q[1]);
		a_lo    = cmd_parser_pkg::hex_val(buf_q[2]);
		rx_addr = {a_hi[3:0], a_lo[3:0]};
		is_wild = buf_q[0] == `CHR_TILDE && buf_q[1] == `CHR_STAR
			&& buf_q[2] == `CHR_STAR && pend == 5'h03;
	end

	always_comb begin
		c1     = cmd_parser_pkg::hex_val(buf_q[3]);
		s_idx  = 5'h04;
		has_ch = 1'b0;
		raw    = 1'b0;
		op_rd  = cmd_parser_pkg::OP_NONE;
		op_wr  = cmd_parser_pkg::OP_NONE;
		loc    = cmd_parser_pkg::ACT_EXT;
		case (buf_q[0])
			`CHR_PCT: begin
				s_idx = 5'h03;
				loc   = cmd_parser_pkg::ACT_CFG_SET;
			end
			`CHR_DOLLAR: begin
				if (buf_q[3] == `CHR_M) loc = cmd_parser_pkg::ACT_NAME;
				else if (c1[4]) begin
					case (c1[3:0])
						4'h2: loc = cmd_parser_pkg::ACT_CFG_RD;
						4'hF: loc = cmd_parser_pkg::ACT_REV;
						4'hB: begin
							op_rd = cmd_parser_pkg::OP_RD_MODE;
							op_wr = cmd_parser_pkg::OP_SET_MODE;
						end
						4'hA: begin
							op_rd = cmd_parser_pkg::OP_RD_GATE;
							op_wr = cmd_parser_pkg::OP_SET_GATE;
						end
						4'h3: begin
							{has_ch, s_idx} = {1'b1, 5'h05};
							op_rd = cmd_parser_pkg::OP_RD_MAX;
							op_wr = cmd_parser_pkg::OP_SET_MAX;
						end
						4'h5: begin
							{has_ch, s_idx} = {1'b1, 5'h05};
							op_rd = cmd_parser_pkg::OP_RD_RUN;
							op_wr = cmd_parser_pkg::OP_SET_RUN;
						end
						4'h6: begin
							{has_ch, s_idx} = {1'b1, 5'h05};
							op_rd = cmd_parser_pkg::OP_CLR_CNT;
						end
						4'h7: begin
							{has_ch, s_idx} = {1'b1, 5'h05};
							op_rd = cmd_parser_pkg::OP_RD_OVF;
						end
						4'h4: begin
							op_rd = cmd_parser_pkg::OP_RD_FILT;
							op_wr = cmd_parser_pkg::OP_SET_FILT;
						end
						4'h0, 4'h1: begin
							s_idx = 5'h05;
							if (buf_q[4] == `CHR_H) begin
								op_rd = c1[0] ? cmd_parser_pkg::OP_RD_TRGH : cmd_parser_pkg::OP_RD_MINH;
								op_wr = c1[0] ? cmd_parser_pkg::OP_SET_TRGH : cmd_parser_pkg::OP_SET_MINH;
							end else if (buf_q[4] == `CHR_L) begin
								op_rd = c1[0] ? cmd_parser_pkg::OP_RD_TRGL : cmd_parser_pkg::OP_RD_MINL;
								op_wr = c1[0] ? cmd_parser_pkg::OP_SET_TRGL : cmd_parser_pkg::OP_SET_MINL;
							end
						end
						default: loc = cmd_parser_pkg::ACT_EXT;
					endcase
				end
			end
			`CHR_HASH: begin
				has_ch = 1'b1;
				op_rd  = cmd_parser_pkg::OP_RD_CNT_HEX;
				if (buf_q[4] == `CHR_D) begin
					s_idx = 5'h05;
					op_rd = cmd_parser_pkg::OP_RD_CNT_DEC;
				end
			end
			`CHR_AT: begin
				s_idx = 5'h05;
				case ({buf_q[3], buf_q[4]})
					{`CHR_E, `CHR_A}: begin
						{has_ch, s_idx} = {1'b1, 5'h06};
						op_rd = cmd_parser_pkg::OP_ALM_ON;
					end
					{`CHR_D, `CHR_A}: begin
						{has_ch, s_idx} = {1'b1, 5'h06};
						op_rd = cmd_parser_pkg::OP_ALM_OFF;
					end
					{`CHR_P, `CHR_A}: op_wr = cmd_parser_pkg::OP_SET_LIM0;
					{`CHR_S, `CHR_A}: op_wr = cmd_parser_pkg::OP_SET_LIM1;
					{`CHR_R, `CHR_P}: op_rd = cmd_parser_pkg::OP_RD_LIM0;
					{`CHR_R, `CHR_A}: op_rd = cmd_parser_pkg::OP_RD_LIM1;
					{`CHR_D, `CHR_O}: op_wr = cmd_parser_pkg::OP_SET_DOUT;
					{`CHR_D, `CHR_I}: op_rd = cmd_parser_pkg::OP_RD_DOUT;
					default: begin
						has_ch = 1'b1;
						if (buf_q[3] == `CHR_P) op_wr = cmd_parser_pkg::OP_SET_INIT;
						if (buf_q[3] == `CHR_G) op_rd = cmd_parser_pkg::OP_RD_INIT;
					end
				endcase
			end
			`CHR_TILDE: begin
				if (c1 == 5'h10) op_rd = cmd_parser_pkg::OP_RD_LEAD;
				if (c1 == 5'h11 && buf_q[4] == `CHR_0) begin
					{raw, s_idx} = {1'b1, 5'h05};
					op_wr = cmd_parser_pkg::OP_SET_LEAD;
				end
				if (c1 == 5'h12) op_wr = cmd_parser_pkg::OP_SET_WDOG;
				if (c1 == 5'h13) op_rd = cmd_parser_pkg::OP_RD_WDOG;
			end
			default: loc = cmd_parser_pkg::ACT_EXT;
		endcase
	end

	// arguments: hex nibbles, or raw characters for the lead code set
	always_comb begin
		arg     = '0;
		all_hex = 1'b1;
		for (int i = 3; i < `RX_DEPTH; i++) begin
			if (i >= int'(s_idx) && i < int'(pend)) begin
				if (raw) arg = {arg[39:0], buf_q[i]};
				else begin
					arg     = {arg[43:0], 4'(cmd_parser_pkg::hex_val(buf_q[i]))};
					all_hex = all_hex & 1'(cmd_parser_pkg::hex_val(buf_q[i]) >> 4);
				end
			end
		end
		cnt       = pend - s_idx;
		// the hash read carries its channel ahead of the optional D
		ch_pos    = (buf_q[0] == `CHR_HASH) ? 5'h03 : s_idx - 5'h01;
		ch_ok     = !has_ch || buf_q[4'(ch_pos)] == `CHR_0
			|| buf_q[4'(ch_pos)] == `CHR_1;
		op        = (cnt == 5'h00) ? op_rd : op_wr;
		syntax_ok = pend >= s_idx && ch_ok && all_hex && cnt <= 5'(`MAX_NIBBLES)
			&& (!raw || cnt == 5'(`LEAD_ARGS)) && op != cmd_parser_pkg::OP_NONE;
		// setup fields: new address, type, baud, flag
		cfg_ok = (arg[23:16] == `TYPE_COUNTER || arg[23:16] == `TYPE_FREQ)
			&& arg[15:8] >= `BAUD_MIN && arg[15:8] <= `BAUD_MAX
			&& (strap_q || (arg[15:8] == baud_q
			&& arg[`FLAG_CKS_BIT] == flag_q[`FLAG_CKS_BIT]));
	end

	always_comb begin
		act = cmd_parser_pkg::ACT_DROP;
		if (!frame_ok) act = cmd_parser_pkg::ACT_DROP;
		else if (is_wild) act = cmd_parser_pkg::ACT_WILD;
		else if (!(a_hi[4] && a_lo[4]) || rx_addr != my_addr) act = cmd_parser_pkg::ACT_DROP;
		else if (loc == cmd_parser_pkg::ACT_EXT) begin
			if (syntax_ok) act = cmd_parser_pkg::ACT_EXT;
		end else if (loc == cmd_parser_pkg::ACT_CFG_SET) begin
			if (cnt == 5'(`CFG_ARGS) && all_hex) act = loc;
		end else if (cnt == 5'h00) act = loc;
	end

	// ****************************************
	// receive buffer
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			len_q <= 5'h00;
			sum_q <= 8'h00;
			ovf_q <= 1'b0;
			for (int i = 0; i < `RX_DEPTH; i++) buf_q[i] <= 8'h00;
		end else if (ce) begin
			if (state_q == cmd_parser_pkg::S_EXEC) begin
				len_q <= 5'h00;
				sum_q <= 8'h00;
				ovf_q <= 1'b0;
			end else if (state_q == cmd_parser_pkg::S_RECV && rx_valid
				&& rx_data != `CHR_CR) begin
				if (len_q < 5'(`RX_DEPTH)) begin
					buf_q[len_q[3:0]] <= rx_data;
					len_q <= len_q + 5'h01;
					sum_q <= sum_q + rx_data;
				end else ovf_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// sequencing
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) state_q <= cmd_parser_pkg::S_RECV;
		else if (ce) begin
			case (state_q)
				cmd_parser_pkg::S_RECV:
					if (rx_valid && rx_data == `CHR_CR && len_q != 5'h00)
						state_q <= cmd_parser_pkg::S_EXEC;
				cmd_parser_pkg::S_EXEC: begin
					case (act)
						cmd_parser_pkg::ACT_DROP, cmd_parser_pkg::ACT_WILD:
							state_q <= cmd_parser_pkg::S_RECV;
						cmd_parser_pkg::ACT_EXT: state_q <= cmd_parser_pkg::S_WAIT;
						default: state_q <= cmd_parser_pkg::S_SEND;
					endcase
				end
				cmd_parser_pkg::S_WAIT: if (rsp_valid) state_q <= cmd_parser_pkg::S_SEND;
				cmd_parser_pkg::S_SEND:
					if (!send_start_q && !busy) state_q <= cmd_parser_pkg::S_RECV;
				default: state_q <= cmd_parser_pkg::S_RECV;
			endcase
		end
	end

	// ****************************************
	// configuration and strap
	// ****************************************
	// strap follows the pin, so default state can be left without a reset
	always_ff @(posedge ref_clk) begin
		if (rst) strap_q <= 1'b0;
		else if (ce) strap_q <= !default_n;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_q   <= `ADDR_RESET;
			type_q   <= `TYPE_COUNTER;
			baud_q   <= `BAUD_RESET;
			flag_q   <= `FLAG_RESET;
			line_bps <= `BPS_BASE;
		end else if (ce) begin
			if (state_q == cmd_parser_pkg::S_EXEC && act == cmd_parser_pkg::ACT_CFG_SET && cfg_ok) begin
				addr_q <= arg[31:24];
				type_q <= arg[23:16];
				baud_q <= arg[15:8];
				flag_q <= arg[7:0];
			end
			line_bps <= `BPS_BASE << (baud_q - `BAUD_MIN);
		end
	end

	assign station_id      = addr_q;
	assign function_code   = type_q;
	assign baud_code       = baud_q;
	assign integrity_field = flag_q;
	assign default_state   = strap_q;

	// ****************************************
	// dispatch to the datapath
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cmd_valid   <= 1'b0;
			cmd         <= '0;
			host_alive  <= 1'b0;
			hold_addr_q <= 8'h00;
			hold_hash_q <= 1'b0;
		end else if (ce) begin
			cmd_valid  <= 1'b0;
			host_alive <= 1'b0;
			if (state_q == cmd_parser_pkg::S_EXEC) begin
				host_alive <= act == cmd_parser_pkg::ACT_WILD;
				if (act == cmd_parser_pkg::ACT_EXT) begin
					cmd_valid   <= 1'b1;
					cmd         <= {op, buf_q[4'(ch_pos)][0], arg, cnt[3:0]};
					hold_addr_q <= rx_addr;
					hold_hash_q <= buf_q[0] == `CHR_HASH;
				end
			end
		end
	end

	// ****************************************
	// response assembly
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			resp_q       <= '0;
			resp_len_q   <= 4'h0;
			resp_cks_q   <= 1'b0;
			send_start_q <= 1'b0;
		end else if (ce) begin
			send_start_q <= 1'b0;
			if (state_q == cmd_parser_pkg::S_EXEC) begin
				// reply under the settings the command arrived with
				resp_cks_q   <= cks_on;
				send_start_q <= act != cmd_parser_pkg::ACT_EXT
					&& act != cmd_parser_pkg::ACT_DROP && act != cmd_parser_pkg::ACT_WILD;
				resp_len_q   <= 4'h3;
				resp_q       <= {96'h0, addr_chars(rx_addr), `CHR_BANG};
				case (act)
					cmd_parser_pkg::ACT_CFG_SET:
						resp_q <= cfg_ok ? {96'h0, addr_chars(arg[31:24]), `CHR_BANG}
							: {96'h0, addr_chars(rx_addr), `CHR_QM};
					cmd_parser_pkg::ACT_CFG_RD: begin
						resp_len_q <= 4'h9;
						resp_q     <= {hex_str({24'h0, type_q, baud_q, flag_q}, 4'h6),
							addr_chars(rx_addr), `CHR_BANG};
					end
					cmd_parser_pkg::ACT_NAME: begin
						resp_len_q <= 4'h7;
						resp_q     <= {hex_str({32'h0, `NAME_CODE}, 4'h4),
							addr_chars(rx_addr), `CHR_BANG};
					end
					cmd_parser_pkg::ACT_REV: begin
						resp_len_q <= 4'h7;
						resp_q     <= {hex_str({32'h0, `REV_CODE}, 4'h4),
							addr_chars(rx_addr), `CHR_BANG};
					end
					default: resp_len_q <= 4'h3;
				endcase
			end else if (state_q == cmd_parser_pkg::S_WAIT && rsp_valid) begin
				send_start_q <= 1'b1;
				if (!rsp.ok) begin
					resp_len_q <= 4'h3;
					resp_q     <= {96'h0, addr_chars(hold_addr_q), `CHR_QM};
				end else if (hold_hash_q) begin
					resp_len_q <= rsp.len + 4'h1;
					resp_q     <= {16'h0, hex_str(rsp.data, rsp.len), `CHR_GT};
				end else begin
					resp_len_q <= rsp.len + 4'h3;
					resp_q     <= {hex_str(rsp.data, rsp.len), addr_chars(hold_addr_q), `CHR_BANG};
				end
			end
		end
	end

	resp_sender u_sender (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.ce       (ce),
		.start    (send_start_q),
		.msg      (resp_q),
		.msg_len  (resp_len_q),
		.cks_en   (resp_cks_q),
		.tx_ready (tx_ready),
		.tx_valid (tx_valid),
		.tx_data  (tx_data),
		.busy     (busy)
	);
endmodule : ascii_command_parser

// ==== parser_asserts.sv ====
// Purpose: port checks of the ascii command parser
// Assumes: ce held high by the bench
// Notes: attached by bind at the foot
`timescale 1ns/1ps
module parser_asserts (
	input logic        ref_clk,
	input logic        rst,
	input logic        ce,
	input logic        tx_ready,
	input logic        tx_valid,
	input logic [7:0]  tx_data,
	input logic        default_n,
	input logic        cmd_valid,
	input logic        rsp_valid,
	input logic        host_alive,
	input logic [7:0]  station_id,
	input logic [7:0]  function_code,
	input logic [7:0]  baud_code,
	input logic [7:0]  integrity_field,
	input logic [15:0] line_bps,
	input logic        default_state
);
	// ****************
	// checks
	// ****************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence rsp_in;
		rsp_valid && ce;
	endsequence
	sequence cr_out;
		tx_valid && tx_ready && ce && tx_data == 8'h0D;
	endsequence
	a_reset_values: assert property ($fell(rst) |-> station_id == 8'h01 &&
		function_code == 8'h50 && baud_code == 8'h06 && integrity_field == 8'h00 && !tx_valid)
		else $error("config not at reset values");
	a_strap_capture: assert property ($fell(rst) |=> default_state == !$past(default_n))
		else $error("strap not captured");
	a_bps_map: assert property (ce && baud_code inside {[8'h03:8'h08]} |=>
		line_bps == 16'h04B0 << ($past(baud_code) - 8'h03)) else $error("bps mismatch");
	a_tx_hold: assert property (tx_valid && !tx_ready && ce |=> tx_valid && $stable(tx_data))
		else $error("tx byte dropped");
	a_frame_end: assert property (cr_out |=> !tx_valid) else $error("bytes after cr");
	a_rsp_lead: assert property (rsp_in |-> ##3 tx_valid && tx_data inside {8'h21, 8'h3E, 8'h3F})
		else $error("bad reply lead");
	a_cmd_pulse: assert property (cmd_valid && ce |=> !cmd_valid) else $error("cmd not pulse");
	a_alive_pulse: assert property (host_alive && ce |=> !host_alive) else $error("alive held");
	a_quiet_fwd: assert property (cmd_valid |-> !tx_valid) else $error("tx while forwarding");
endmodule : parser_asserts
bind ascii_command_parser parser_asserts chk (.ref_clk, .rst, .ce, .tx_ready, .tx_valid,
	.tx_data, .default_n, .cmd_valid, .rsp_valid, .host_alive, .station_id, .function_code,
	.baud_code, .integrity_field, .line_bps, .default_state);

// ==== serial_host.sv ====
// Purpose: host side of the serial link
// Assumes: one frame at a time
// Notes: stalls tx_ready when slow is set
`timescale 1ns/1ps
module serial_host (
	input  logic       ref_clk,
	input  logic       tx_valid,
	input  logic [7:0] tx_data,
	output logic       rx_valid,
	output logic [7:0] rx_data,
	output logic       tx_ready
);
	// ****************
	// link model
	// ****************
	logic [7:0] got[$];
	logic       slow  = 1'b0;
	logic [1:0] cnt_q = 2'h0;
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		tx_ready = 1'b1;
	end
	always @(posedge ref_clk) begin
		cnt_q <= cnt_q + 2'h1;
		tx_ready <= !slow || cnt_q == 2'h0;
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
	end
	task automatic send(input string s);
		foreach (s[i]) begin
			@(posedge ref_clk);
			rx_valid <= 1'b1;
			rx_data  <= s[i];
		end
		@(posedge ref_clk);
		rx_data <= 8'h0D;
		@(posedge ref_clk);
		rx_valid <= 1'b0;
		rx_data  <= ~rx_data;
	endtask : send
endmodule : serial_host

// ==== tb_ascii_command_parser.sv ====
// Purpose: self-checking bench of the command parser
// Assumes: datapath answers one cycle after each command
// Notes: checksum is tried after the strap is let go
`timescale 1ns/1ps
module tb_ascii_command_parser;
	// ****************
	// bench
	// ****************
	logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, default_n = 1'b1, alive_q = 1'b0;
	logic rsp_valid = 1'b0;
	logic rx_valid, tx_ready, tx_valid, cmd_valid, host_alive, default_state;
	logic [7:0] rx_data, tx_data, station_id, function_code, baud_code, integrity_field;
	logic [15:0] line_bps;
	cmd_parser_pkg::cmd_t cmd;
	cmd_parser_pkg::rsp_t rsp = '{1'b1, 48'h0000FFFF, 4'h8};
	int comparisons = 0, miscompares = 0;
	string fr[14] = '{"$01A", "$0130", "@01G1", "$0160", "$014", "$011L", "@01DI", "~013",
		"$01B1", "$0130FF", "@01EA1", "@01PA12", "~0110ABCDEF", "@01DO03"};
	cmd_parser_pkg::opcode_t ops[14] = '{cmd_parser_pkg::OP_RD_GATE, cmd_parser_pkg::OP_RD_MAX,
		cmd_parser_pkg::OP_RD_INIT, cmd_parser_pkg::OP_CLR_CNT, cmd_parser_pkg::OP_RD_FILT,
		cmd_parser_pkg::OP_RD_TRGL, cmd_parser_pkg::OP_RD_DOUT, cmd_parser_pkg::OP_RD_WDOG,
		cmd_parser_pkg::OP_SET_MODE, cmd_parser_pkg::OP_SET_MAX, cmd_parser_pkg::OP_ALM_ON,
		cmd_parser_pkg::OP_SET_LIM0, cmd_parser_pkg::OP_SET_LEAD, cmd_parser_pkg::OP_SET_DOUT};
	ascii_command_parser DUT (.ref_clk, .rst, .ce, .rx_valid, .rx_data, .tx_ready, .tx_valid,
		.tx_data, .default_n, .cmd_valid, .cmd, .rsp_valid, .rsp, .host_alive, .station_id,
		.function_code, .baud_code, .integrity_field, .line_bps, .default_state);
	serial_host host (.ref_clk, .tx_valid, .tx_data, .rx_valid, .rx_data, .tx_ready);
	initial forever #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		rsp_valid <= cmd_valid;
		if (host_alive)
			alive_q <= 1'b1;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic do_reset(input logic strap);
		default_n <= strap;
		rst <= 1'b1;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask : do_reset
	// "*" waits for the reply without checking it, "" expects silence
	task automatic xact(input string f, input string e);
		int n;
		host.got.delete();
		host.send(f);
		for (n = 0; n < 150; n++) begin
			@(posedge ref_clk);
			if (host.got.size() > 0 && host.got[$] === 8'h0D) break;
			if (e.len() == 0 && n == 40) break;
		end
		if (n == 150) begin
			miscompares++;
			tally_and_finish();
		end else if (e != "*") begin
			chk(64'(host.got.size()), 64'(e.len() + (e.len() != 0)));
			foreach (e[i]) chk(host.got[i], e[i]);
			if (e.len() != 0) chk(host.got[e.len()], 8'h0D);
		end
	endtask : xact
	initial begin
		do_reset(1'b1);
		xact("$012", "!01500600");
		xact("$01M", "!011234");
		host.slow <= 1'b1;
		xact("$01F", "!010100");
		host.slow <= 1'b0;
		xact("$022", "");
		xact("#010", ">0000FFFF");
		chk(cmd.op, cmd_parser_pkg::OP_RD_CNT_HEX);
		rsp.ok <= 1'b0;
		xact("#011D", "?01");
		chk({cmd.op, cmd.channel_select}, {cmd_parser_pkg::OP_RD_CNT_DEC, 1'b1});
		rsp.ok <= 1'b1;
		foreach (fr[i]) begin
			xact(fr[i], "*");
			chk(cmd.op, ops[i]);
		end
		chk({cmd.arg, cmd.arg_len}, {48'h03, 4'h2});
		xact("~**", "");
		chk(alive_q, 1'b1);
		xact("%0130500600", "!30");
		chk(station_id, 8'h30);
		xact("%3030510600", "!30");
		chk(function_code, 8'h51);
		xact("%3030510700", "?30");
		chk(baud_code, 8'h06);
		xact("$302", "!30510600");
		do_reset(1'b0);
		chk(default_state, 1'b1);
		xact("$002", "!00500600");
		xact("%0000500741", "!00");
		chk({baud_code, integrity_field}, 16'h0741);
		chk(line_bps, 16'h4B00);
		default_n <= 1'b1;
		xact("$002B6", "!00500741B2");
		chk(default_state, 1'b0);
		xact("$002B7", "");
		tally_and_finish();
	end
endmodule : tb_ascii_command_parser
